// file: rtl/pawps_pkg.sv
/*
  Constants for the six-line general purpose port with pin steering:
  register offsets, writable masks, reset values, steering bit positions
  and the pin location codes used by the steering logic.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package pawps_pkg;

  // ----------------------------------------------------------------------
  // register map, byte addresses on the bus
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_PIN_VALUE = 8'h00;
  localparam logic [7:0] OFS_DIRECTION = 8'h04;
  localparam logic [7:0] OFS_LATCH = 8'h08;
  localparam logic [7:0] OFS_ANALOG = 8'h0c;
  localparam logic [7:0] OFS_STEERING = 8'h10;

  // ----------------------------------------------------------------------
  // implemented bits and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] PIN_MASK = 8'h3f;
  localparam logic [7:0] DIR_MASK = 8'h37;
  localparam logic [7:0] DIR_FIXED = 8'h08;
  localparam logic [7:0] DIR_RESET = 8'h3f;
  localparam logic [7:0] LATCH_MASK = 8'h37;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] ANALOG_MASK = 8'h17;
  localparam logic [7:0] ANALOG_RESET = 8'h17;
  localparam logic [7:0] STEER_MASK = 8'hef;
  localparam logic [7:0] STEER_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // steering register bit positions
  // ----------------------------------------------------------------------
  localparam int unsigned SERIAL_RECEIVE_SEL = 7;
  localparam int unsigned SERIAL_OUT_SEL = 6;
  localparam int unsigned SLAVE_SELECT_SEL = 5;
  localparam int unsigned TIMER_GATE_SEL = 3;
  localparam int unsigned SERIAL_TRANSMIT_SEL = 2;
  localparam int unsigned SECONDARY_PWM_SEL = 1;
  localparam int unsigned CAPTURE_COMPARE_SEL = 0;

  localparam int unsigned LINES = 6;
  localparam int unsigned INPUT_ONLY_LINE = 3;
  localparam int unsigned OUT_FUNCS = 5;

  // ----------------------------------------------------------------------
  // pin locations: top bit set means port C, low bits the line
  // ----------------------------------------------------------------------
  typedef logic [3:0] pawps_loc_t;
  localparam pawps_loc_t LOC_A0 = 4'h0;
  localparam pawps_loc_t LOC_A1 = 4'h1;
  localparam pawps_loc_t LOC_A2 = 4'h2;
  localparam pawps_loc_t LOC_A3 = 4'h3;
  localparam pawps_loc_t LOC_A4 = 4'h4;
  localparam pawps_loc_t LOC_A5 = 4'h5;
  localparam pawps_loc_t LOC_C2 = 4'ha;
  localparam pawps_loc_t LOC_C3 = 4'hb;
  localparam pawps_loc_t LOC_C4 = 4'hc;
  localparam pawps_loc_t LOC_C5 = 4'hd;

endpackage

// file: rtl/pawps_pin_cell.sv
/*
  One port line: output driver control and the digital input path.
  Assumes the pin level arrives synchronous to clk_i and that the
  steering logic above supplies any peripheral drive request.
*/
`timescale 1ns/1ps

module pawps_pin_cell #(
  parameter bit INPUT_ONLY = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dir_i,
  input wire logic latch_i,
  input wire logic analog_i,
  input wire logic fn_en_i,
  input wire logic fn_val_i,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_n_o,
  output logic digital_o
);

  // ----------------------------------------------------------------------
  // driver: a steered peripheral wins over the port latch
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || INPUT_ONLY) begin
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
    end else if (fn_en_i) begin
      pin_o <= fn_val_i;
      pin_oe_n_o <= 1'b0;
    end else begin
      // analog select plays no part here, only direction does
      pin_o <= latch_i;
      pin_oe_n_o <= dir_i;
    end
  end

  // input buffer is off in analog mode, so reads see zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      digital_o <= 1'b0;
    end else begin
      digital_o <= pin_i & ~analog_i;
    end
  end

endmodule

// file: rtl/pawps_top.sv
/*
  Six-line general purpose port with direction, output latch, analog
  select and the steering register that moves peripheral signals between
  pins, reached over a classic Wishbone slave.
  Assumes pins and port C levels are synchronous to clk_i and that the
  bus master holds each request until it sees ack.
*/
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps

// Overview of operation
// - receive/data steering bit 7 picks its pin, mapping per variant.
// - serial data-out steering bit 6 picks its pin, mapping per variant.
// - slave-select steering bit 5 picks its pin, mapping per variant.
// - timer gate from line 4 when bit 3 clear, line 3 when set.
// - transmit/clock steering bit 2 picks its pin, mapping per variant.
// - secondary PWM on line 0 or 4 by bit 1; 14-pin fixed C4.
// - 8-pin: capture/compare on line 2 when bit 0 clear, line 5 set.
// - steering bit 4 reads zero; steering bits reset to zero.
// - six lines, each with a direction bit; all but line 3 bidirectional with a latch bit.
// - direction one disables the line's driver; line is an input.
// - direction zero drives the line with its output latch.
// - line 3 is input only; its direction bit always reads one.
// - port read returns pin levels; port write updates the latch.
// - port write with no byte lane stores the sensed pins in the latch.
// - direction keeps driver control even on analog-selected lines.
// - analog-selected lines read zero on every digital read.
// - analog select does not affect digital output drive.
// - steering changes leave direction alone; overrides follow function.
// - latch register read returns latch contents, not pin levels.
// - all direction bits reset to one, every line an input.
module pawps_top #(
  parameter bit EIGHT_PIN = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [5:0] pin_i,
  output logic [5:0] pin_o,
  output logic [5:0] pin_oe_n_o,
  input wire logic [5:0] port_c_pin_i,
  output logic [5:0] port_c_fn_out_o,
  output logic [5:0] port_c_fn_en_o,
  input wire logic serial_transmit_clock_i,
  input wire logic serial_transmit_clock_en_i,
  input wire logic serial_data_out_i,
  input wire logic serial_data_out_en_i,
  input wire logic secondary_pwm_output_i,
  input wire logic secondary_pwm_output_en_i,
  input wire logic serial_receive_data_i,
  input wire logic serial_receive_data_en_i,
  input wire logic capture_compare_primary_pwm_i,
  input wire logic capture_compare_primary_pwm_en_i,
  output logic serial_receive_data_o,
  output logic slave_select_o,
  output logic timer_gate_input_o,
  output logic capture_compare_primary_pwm_o
);

  // ----------------------------------------------------------------------
  // registers and shared nets
  // ----------------------------------------------------------------------
  logic [7:0] port_direction;
  logic [7:0] port_output_latch;
  logic [7:0] port_analog_select;
  logic [7:0] alternate_pin_steering;
  logic [5:0] digital_in;
  logic [5:0] pa_fn_en;
  logic [5:0] pa_fn_val;
  logic [5:0] next_pc_en;
  logic [5:0] next_pc_val;
  logic [7:0] pin_read;
  logic [7:0] rd_data;
  logic req;
  logic wr_now;
  logic sel_lo;
  pawps_pkg::pawps_loc_t loc_tx;
  pawps_pkg::pawps_loc_t loc_sdo;
  pawps_pkg::pawps_loc_t loc_pwm;
  pawps_pkg::pawps_loc_t loc_rx;
  pawps_pkg::pawps_loc_t loc_ccp;
  pawps_pkg::pawps_loc_t loc_ss;
  pawps_pkg::pawps_loc_t loc_gate;
  pawps_pkg::pawps_loc_t fn_loc [pawps_pkg::OUT_FUNCS];
  logic [4:0] fn_val;
  logic [4:0] fn_en;

  // ----------------------------------------------------------------------
  // bus slave: ack one cycle after the request, writes land on ack
  // ----------------------------------------------------------------------
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_now = req & wb_we_i & wb_ack_o;
  assign sel_lo = wb_sel_i[0];

  // ack drops the cycle after it rises, even if the master lingers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  // pin levels as a digital read sees them
  assign pin_read = {2'b00, digital_in} & pawps_pkg::PIN_MASK;

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_data = 8'h00;
    case ({wb_adr_i[7:2], 2'b00})
      pawps_pkg::OFS_PIN_VALUE: rd_data = pin_read;
      pawps_pkg::OFS_DIRECTION: rd_data = port_direction;
      pawps_pkg::OFS_LATCH: rd_data = port_output_latch;
      pawps_pkg::OFS_ANALOG: rd_data = port_analog_select;
      pawps_pkg::OFS_STEERING: rd_data = alternate_pin_steering;
      default: rd_data = 8'h00;
    endcase
  end

  // read data is captured with the request and held through ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req & ~wb_ack_o & ~wb_we_i) begin
      wb_dat_o <= {24'h00_0000, rd_data};
    end
  end

  // ----------------------------------------------------------------------
  // port registers
  // ----------------------------------------------------------------------
  // direction: line 3 is forced to input whatever is written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_direction <= pawps_pkg::DIR_RESET;
    end else if (wr_now && sel_lo &&
                 wb_adr_i[7:2] == pawps_pkg::OFS_DIRECTION[7:2]) begin
      port_direction <= (wb_dat_i[7:0] & pawps_pkg::DIR_MASK) |
                        pawps_pkg::DIR_FIXED;
    end
  end

  // latch: port writes without the low byte lane store sensed pins, latch writes are plain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_output_latch <= pawps_pkg::LATCH_RESET;
    end else if (wr_now &&
                 wb_adr_i[7:2] == pawps_pkg::OFS_PIN_VALUE[7:2]) begin
      // without the low byte lane the sensed levels are written back
      port_output_latch <= (sel_lo ? wb_dat_i[7:0] : pin_read) &
                           pawps_pkg::LATCH_MASK;
    end else if (wr_now && sel_lo &&
                 wb_adr_i[7:2] == pawps_pkg::OFS_LATCH[7:2]) begin
      port_output_latch <= wb_dat_i[7:0] & pawps_pkg::LATCH_MASK;
    end
  end

  // analog select only gates the input path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_analog_select <= pawps_pkg::ANALOG_RESET;
    end else if (wr_now && sel_lo &&
                 wb_adr_i[7:2] == pawps_pkg::OFS_ANALOG[7:2]) begin
      port_analog_select <= wb_dat_i[7:0] & pawps_pkg::ANALOG_MASK;
    end
  end

  // steering: touches nothing but itself, direction stays as it was
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alternate_pin_steering <= pawps_pkg::STEER_RESET;
    end else if (wr_now && sel_lo &&
                 wb_adr_i[7:2] == pawps_pkg::OFS_STEERING[7:2]) begin
      alternate_pin_steering <= wb_dat_i[7:0] &
                                pawps_pkg::STEER_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // steering map, chosen per variant
  // ----------------------------------------------------------------------
  always_comb begin
    if (EIGHT_PIN) begin
      loc_rx = alternate_pin_steering[pawps_pkg::SERIAL_RECEIVE_SEL] ?
               pawps_pkg::LOC_A5 : pawps_pkg::LOC_A1;
      loc_sdo = alternate_pin_steering[pawps_pkg::SERIAL_OUT_SEL] ?
                pawps_pkg::LOC_A4 : pawps_pkg::LOC_A0;
      loc_ss = alternate_pin_steering[pawps_pkg::SLAVE_SELECT_SEL] ?
               pawps_pkg::LOC_A0 : pawps_pkg::LOC_A3;
      loc_tx = alternate_pin_steering[pawps_pkg::SERIAL_TRANSMIT_SEL] ?
               pawps_pkg::LOC_A4 : pawps_pkg::LOC_A0;
      loc_pwm = alternate_pin_steering[pawps_pkg::SECONDARY_PWM_SEL] ?
                pawps_pkg::LOC_A4 : pawps_pkg::LOC_A0;
      loc_ccp = alternate_pin_steering[pawps_pkg::CAPTURE_COMPARE_SEL] ?
                pawps_pkg::LOC_A5 : pawps_pkg::LOC_A2;
    end else begin
      loc_rx = alternate_pin_steering[pawps_pkg::SERIAL_RECEIVE_SEL] ?
               pawps_pkg::LOC_A1 : pawps_pkg::LOC_C5;
      loc_sdo = alternate_pin_steering[pawps_pkg::SERIAL_OUT_SEL] ?
                pawps_pkg::LOC_A4 : pawps_pkg::LOC_C2;
      loc_ss = alternate_pin_steering[pawps_pkg::SLAVE_SELECT_SEL] ?
               pawps_pkg::LOC_A3 : pawps_pkg::LOC_C3;
      loc_tx = alternate_pin_steering[pawps_pkg::SERIAL_TRANSMIT_SEL] ?
               pawps_pkg::LOC_A0 : pawps_pkg::LOC_C4;
      loc_pwm = pawps_pkg::LOC_C4;
      // the wide variant has no choice for capture/compare
      loc_ccp = pawps_pkg::LOC_C5;
    end
    loc_gate = alternate_pin_steering[pawps_pkg::TIMER_GATE_SEL] ?
               pawps_pkg::LOC_A3 : pawps_pkg::LOC_A4;
  end

  // output functions, highest priority first
  always_comb begin
    fn_loc[0] = loc_tx;
    fn_loc[1] = loc_sdo;
    fn_loc[2] = loc_pwm;
    fn_loc[3] = loc_rx;
    fn_loc[4] = loc_ccp;
  end
  assign fn_val = {capture_compare_primary_pwm_i, serial_receive_data_i,
                   secondary_pwm_output_i, serial_data_out_i,
                   serial_transmit_clock_i};
  assign fn_en = {capture_compare_primary_pwm_en_i, serial_receive_data_en_i,
                  secondary_pwm_output_en_i, serial_data_out_en_i,
                  serial_transmit_clock_en_i};

  // resolve drive requests per pin; lower index overwrites, so it wins
  always_comb begin
    pa_fn_en = 6'h00;
    pa_fn_val = 6'h00;
    next_pc_en = 6'h00;
    next_pc_val = 6'h00;
    for (int f = pawps_pkg::OUT_FUNCS - 1; f >= 0; f--) begin
      for (int p = 0; p < pawps_pkg::LINES; p++) begin
        if (fn_en[f] && fn_loc[f] == {1'b0, 3'(p)}) begin
          pa_fn_en[p] = 1'b1;
          pa_fn_val[p] = fn_val[f];
        end
        if (fn_en[f] && fn_loc[f] == {1'b1, 3'(p)}) begin
          next_pc_en[p] = 1'b1;
          next_pc_val[p] = fn_val[f];
        end
      end
    end
  end

  // port C requests leave as registered drive requests
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_c_fn_en_o <= 6'h00;
      port_c_fn_out_o <= 6'h00;
    end else begin
      port_c_fn_en_o <= next_pc_en;
      port_c_fn_out_o <= next_pc_val;
    end
  end

  // level seen at a location: port A lines through the digital input path, port C lines straight from port_c_pin_i
  function automatic logic level_at(input pawps_pkg::pawps_loc_t loc,
                                    input logic [5:0] pa,
                                    input logic [5:0] pc);
    logic lvl;
    lvl = 1'b0;
    for (int p = 0; p < pawps_pkg::LINES; p++) begin
      if (loc[2:0] == 3'(p)) begin
        lvl = loc[3] ? pc[p] : pa[p];
      end
    end
    return lvl;
  endfunction

  // peripheral inputs follow their function to the selected pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_receive_data_o <= 1'b0;
      slave_select_o <= 1'b0;
      timer_gate_input_o <= 1'b0;
      capture_compare_primary_pwm_o <= 1'b0;
    end else begin
      serial_receive_data_o <= level_at(loc_rx, digital_in,
                                        port_c_pin_i);
      slave_select_o <= level_at(loc_ss, digital_in, port_c_pin_i);
      timer_gate_input_o <= level_at(loc_gate, digital_in,
                                     port_c_pin_i);
      capture_compare_primary_pwm_o <= level_at(loc_ccp, digital_in,
                                                port_c_pin_i);
    end
  end

  // ----------------------------------------------------------------------
  // the six line cells
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < pawps_pkg::LINES; g++) begin : g_line
    pawps_pin_cell #(
      .INPUT_ONLY(g == pawps_pkg::INPUT_ONLY_LINE)
    ) u_cell (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .dir_i(port_direction[g]),
      .latch_i(port_output_latch[g]),
      .analog_i(port_analog_select[g]),
      .fn_en_i(pa_fn_en[g]),
      .fn_val_i(pa_fn_val[g]),
      .pin_i(pin_i[g]),
      .pin_o(pin_o[g]),
      .pin_oe_n_o(pin_oe_n_o[g]),
      .digital_o(digital_in[g])
    );
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  steer_bit4_a: assert property (
    wb_ack_o && !wb_we_i &&
    wb_adr_i[7:2] == pawps_pkg::OFS_STEERING[7:2] |-> wb_dat_o[4] == 1'b0)
    else $error("steering bit 4 read as one");
  steer_reset_a: assert property (
    $past(rst_i) |-> alternate_pin_steering == 8'h00)
    else $error("steering not zero after reset");
  dir_reset_a: assert property (
    $past(rst_i) |-> port_direction == 8'h3f)
    else $error("direction not all inputs after reset");
  line3_input_a: assert property (
    $past(rst_i) || (pin_oe_n_o[3] && port_direction[3]))
    else $error("input-only line driven or direction cleared");
  dir_release_a: assert property (
    port_direction[1] && !pa_fn_en[1] |=> pin_oe_n_o[1])
    else $error("driver on while direction is input");
  dir_drive_a: assert property (
    !port_direction[1] && !pa_fn_en[1] |=>
    !pin_oe_n_o[1] && pin_o[1] == $past(port_output_latch[1]))
    else $error("driver off or wrong value while output");
  analog_drive_a: assert property (
    port_analog_select[0] && !port_direction[0] && !pa_fn_en[0] |=>
    !pin_oe_n_o[0])
    else $error("analog select blocked digital output");
  pin_read_a: assert property (
    req && !wb_we_i && !wb_ack_o &&
    wb_adr_i[7:2] == pawps_pkg::OFS_PIN_VALUE[7:2] |=>
    wb_ack_o && (wb_dat_o[5:0] & $past(port_analog_select[5:0])) == 6'h00)
    else $error("analog line read nonzero or ack late");
  rmw_write_a: assert property (
    wr_now && !sel_lo && wb_adr_i[7:2] == pawps_pkg::OFS_PIN_VALUE[7:2]
    |=> port_output_latch == ($past(pin_read) & 8'h37))
    else $error("port write did not store sensed pins");
  latch_write_a: assert property (
    wr_now && sel_lo && wb_adr_i[7:2] == pawps_pkg::OFS_PIN_VALUE[7:2]
    |=> port_output_latch == ($past(wb_dat_i[7:0]) & 8'h37))
    else $error("port write did not reach the latch");
  steer_dir_a: assert property (
    wr_now && wb_adr_i[7:2] == pawps_pkg::OFS_STEERING[7:2] |=>
    $stable(port_direction))
    else $error("steering write changed direction");
  gate_route_a: assert property (
    alternate_pin_steering[3] ##1 alternate_pin_steering[3] |->
    timer_gate_input_o == $past(digital_in[3]))
    else $error("timer gate not taken from line 3");

  read_seen_c: cover property (req && !wb_we_i ##1 wb_ack_o);
  rmw_seen_c: cover property (wr_now && !sel_lo);
  steer_seen_c: cover property (alternate_pin_steering[2] && fn_en[0]);
  drive_seen_c: cover property (!pin_oe_n_o[5]);

endmodule

// file: verification/pawps_tb_top.sv
/*
  Self-checking bench for the six-line port with pin steering.
  Assumes pawps_top in both steering maps (the 14-pin copy shares every
  input and is checked in the steering loop) and a one-cycle
  Wishbone answer; pins and peripheral signals are driven by the bench.
*/
`timescale 1ns/1ps

module pawps_tb_top;
  // ----------------------------------------------------------------------
  // signals and case table
  // ----------------------------------------------------------------------
  typedef struct {
    logic w;
    logic [7:0] adr;
    logic [7:0] wd;
    logic [7:0] exp;
  } pawps_row_t;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic ack;
  logic [5:0] pin_i = 6'h00;
  logic [5:0] pin_o;
  logic [5:0] oe_n;
  logic [5:0] pc_pin = 6'h00;
  logic [5:0] pc_out;
  logic [5:0] pc_en;
  logic [9:0] per = 10'h000; // value/enable pairs, one per function
  logic rx_o, ss_o, tg_o, ccp_o;
  logic [5:0] oe_n14;
  logic [5:0] pc_out14;
  logic [5:0] pc_en14;
  logic rx14;
  logic ss14;
  logic [7:0] rd;
  logic [7:0] s;
  int errors = 0;
  int checks = 0;
  int pos [3] = '{2, 6, 1}; // steering bit of transmit, data out, pwm
  // first four rows read reset values, the rest write then read back
  pawps_row_t rows [11] = '{
    '{1'b0, pawps_pkg::OFS_DIRECTION, 8'h00, 8'h3f},
    '{1'b0, pawps_pkg::OFS_LATCH, 8'h00, 8'h00},
    '{1'b0, pawps_pkg::OFS_ANALOG, 8'h00, 8'h17},
    '{1'b0, pawps_pkg::OFS_STEERING, 8'h00, 8'h00},
    '{1'b1, pawps_pkg::OFS_DIRECTION, 8'h00, 8'h08},
    '{1'b1, pawps_pkg::OFS_LATCH, 8'hff, 8'h37},
    '{1'b1, pawps_pkg::OFS_ANALOG, 8'h00, 8'h00},
    '{1'b1, pawps_pkg::OFS_STEERING, 8'hff, 8'hef},
    '{1'b1, pawps_pkg::OFS_STEERING, 8'h00, 8'h00},
    '{1'b1, 8'h14, 8'hff, 8'h00},
    '{1'b1, pawps_pkg::OFS_LATCH, 8'h15, 8'h15}};

  pawps_top pawps_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n_o(oe_n), .port_c_pin_i(pc_pin), .port_c_fn_out_o(pc_out),
    .port_c_fn_en_o(pc_en), .serial_transmit_clock_i(per[0]),
    .serial_transmit_clock_en_i(per[1]), .serial_data_out_i(per[2]),
    .serial_data_out_en_i(per[3]), .secondary_pwm_output_i(per[4]),
    .secondary_pwm_output_en_i(per[5]), .serial_receive_data_i(per[6]),
    .serial_receive_data_en_i(per[7]),
    .capture_compare_primary_pwm_i(per[8]),
    .capture_compare_primary_pwm_en_i(per[9]),
    .serial_receive_data_o(rx_o), .slave_select_o(ss_o),
    .timer_gate_input_o(tg_o), .capture_compare_primary_pwm_o(ccp_o));

  // the 14-pin map, fed the same stimulus as the 8-pin copy
  pawps_top #(
    .EIGHT_PIN(1'b0)
  ) pawps_top_inst_wide (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(), .wb_ack_o(), .pin_i(pin_i), .pin_o(),
    .pin_oe_n_o(oe_n14), .port_c_pin_i(pc_pin), .port_c_fn_out_o(pc_out14),
    .port_c_fn_en_o(pc_en14), .serial_transmit_clock_i(per[0]),
    .serial_transmit_clock_en_i(per[1]), .serial_data_out_i(per[2]),
    .serial_data_out_en_i(per[3]), .secondary_pwm_output_i(per[4]),
    .secondary_pwm_output_en_i(per[5]), .serial_receive_data_i(per[6]),
    .serial_receive_data_en_i(per[7]),
    .capture_compare_primary_pwm_i(per[8]),
    .capture_compare_primary_pwm_en_i(per[9]),
    .serial_receive_data_o(rx14), .slave_select_o(ss14),
    .timer_gate_input_o(), .capture_compare_primary_pwm_o());

  // ----------------------------------------------------------------------
  // clock, watchdog and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // about 135 cycles are expected; a stuck bus times out in the bus task, any other hang ends the run here
  initial begin
    repeat (3000) @(posedge clk_i);
    errors++;
    wrap_up();
  end

  task automatic check(input string name, input logic [7:0] seen,
    input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle; the request stands until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [7:0] d, input logic s0, output logic [7:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    sel <= {3'h0, s0};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) errors++;
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    check("oe_n at reset", {2'h0, oe_n}, 8'h3f);
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'b1, rows[i].adr, rows[i].wd, 1'b1, rd);
      bus(1'b0, rows[i].adr, 8'h00, 1'b1, rd);
      check("register", rd, rows[i].exp);
    end
    check("oe_n output", {2'h0, oe_n}, 8'h08);
    check("drive", {2'h0, pin_o}, 8'h15);
    pin_i <= 6'h2a;
    repeat (2) @(posedge clk_i);
    bus(1'b0, pawps_pkg::OFS_PIN_VALUE, 8'h00, 1'b1, rd);
    check("pins", rd, 8'h2a);
    bus(1'b1, pawps_pkg::OFS_ANALOG, 8'h17, 1'b1, rd);
    bus(1'b0, pawps_pkg::OFS_PIN_VALUE, 8'h00, 1'b1, rd);
    check("analog pins", rd, 8'h28);
    check("oe_n analog", {2'h0, oe_n}, 8'h08);
    check("drive analog", {2'h0, pin_o}, 8'h15);
    bus(1'b1, pawps_pkg::OFS_PIN_VALUE, 8'h0a, 1'b1, rd);
    bus(1'b0, pawps_pkg::OFS_LATCH, 8'h00, 1'b1, rd);
    check("port write", rd, 8'h02);
    // no byte lane: the sensed, analog-masked pins land in the latch
    bus(1'b1, pawps_pkg::OFS_PIN_VALUE, 8'hff, 1'b0, rd);
    bus(1'b0, pawps_pkg::OFS_LATCH, 8'h00, 1'b1, rd);
    check("rmw", rd, 8'h20);
    // all lines back to inputs before analog select is touched again
    bus(1'b1, pawps_pkg::OFS_DIRECTION, 8'h3f, 1'b1, rd);
    bus(1'b1, pawps_pkg::OFS_ANALOG, 8'h00, 1'b1, rd);
    pin_i <= 6'h17;
    // port C line 3 high only, so each port C choice reads apart
    pc_pin <= 6'h08;
    // both settings of every steering bit, inputs then the transmit, data out and pwm outputs
    for (int i = 0; i < 2; i++) begin
      s = i ? 8'hef : 8'h00;
      bus(1'b1, pawps_pkg::OFS_STEERING, s, 1'b1, rd);
      repeat (3) @(posedge clk_i);
      check("receive", {7'h0, rx_o}, {7'h0, ~s[7]});
      check("slave select", {7'h0, ss_o}, {7'h0, s[5]});
      check("timer gate", {7'h0, tg_o}, {7'h0, ~s[3]});
      check("capture", {7'h0, ccp_o}, {7'h0, ~s[0]});
      check("wide receive", {7'h0, rx14}, {7'h0, s[7]});
      check("wide slave sel", {7'h0, ss14}, {7'h0, ~s[5]});
      bus(1'b0, pawps_pkg::OFS_DIRECTION, 8'h00, 1'b1, rd);
      check("dir kept", rd, 8'h3f);
      for (int j = 0; j < 3; j++) begin
        per <= 10'h003 << (2 * j);
        repeat (3) @(posedge clk_i);
        check("fn oe_n", {2'h0, oe_n}, s[pos[j]] ? 8'h2f : 8'h3e);
        check("fn drive", {7'h0, s[pos[j]] ? pin_o[4] : pin_o[0]},
          8'h01);
        check("port c", {2'h0, pc_en | pc_out}, 8'h00);
        // the wide map moves transmit and data out only; pwm stays on C4
        check("wide oe_n", {2'h0, oe_n14},
          (s[pos[j]] && j < 2) ? (j ? 8'h2f : 8'h3e) : 8'h3f);
        check("wide port c", {2'h0, pc_en14 & pc_out14},
          (s[pos[j]] && j < 2) ? 8'h00 : j == 1 ? 8'h04 : 8'h10);
      end
      per <= 10'h000;
    end
    // second reset in mid-run clears steering and restores inputs;
    // lines are made outputs first so the reset has something to undo
    bus(1'b1, pawps_pkg::OFS_DIRECTION, 8'h00, 1'b1, rd);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, pawps_pkg::OFS_STEERING, 8'h00, 1'b1, rd);
    check("steer reset", rd, 8'h00);
    check("oe_n reset", {2'h0, oe_n}, 8'h3f);
    wrap_up();
  end
endmodule
